// >>> logic/adc_rate_defines.svh
// Purpose: offsets, field positions, reset values and timing counts
// Assumes: pclk at 125 MHz, byte addresses on a 32-bit APB
// Notes: included by the converter control files by bare name
// Notes on behaviour
// - Running on the internal oscillator of 153.6kHz, a result comes 7.5 times a second with the notch at 60Hz.
// - A steady low on the frequency-select pin picks the internal clock with a 60Hz notch, a steady high the 50Hz one.
// - A clock toggling on the frequency-select pin becomes the conversion clock, one result per 20480 of its periods.
// - Each conversion stands alone, so a fast-rate result followed by a slow-rate one carries nothing over.
// - The result word is done bit, fixed-low bit, sign, range flag, then 20-bit code; over reference wraps, under zero gives ones.
// - An input of zero gives a zero code with the range flag low and the sign flag high.
// - Inputs beyond 1.125 or below -0.125 of reference clamp to the codes of those limits.
// - One bit leaves per serial clock, the word ends on the 24th falling edge, and later clocks read high.
`ifndef ADC_RATE_DEFINES_SVH
`define ADC_RATE_DEFINES_SVH

`define CLK_HZ 125000000
`define OSC60_HZ 153600
`define OSC50_HZ 128000
`define CONV_TICKS 20480
`define EXT_TIMEOUT_NS 1000000
`define CLK_PERIOD_NS 8
`define WORD_BITS 24
`define CODE_BITS 20
`define CLAMP_HI 24'h11FFFF
`define CLAMP_LO 24'hFE0000
`define FULL_SCALE 24'h100000

`define OFF_CTRL 12'h000
`define OFF_STATUS 12'h004
`define OFF_RESULT 12'h008
`define OFF_INT_STAT 12'h00C
`define OFF_INT_MASK 12'h010

`define CTRL_RUN_BIT 0
`define CTRL_RESET 32'h0000_0001
`define INT_MASK_RESET 3'h0
`define INT_DONE_BIT 0
`define INT_SENT_BIT 1
`define INT_ABORT_BIT 2
`define STATUS_BUSY_BIT 2
`define STATUS_READY_BIT 3

`endif

// >>> logic/adc_rate_pkg.sv
// Purpose: shared types of the converter control block
// Assumes: constants live in adc_rate_defines.svh
// Notes: none
package adc_rate_pkg;
   typedef enum logic [1:0] {
      MODE_INT60 = 2'b00,
      MODE_INT50 = 2'b01,
      MODE_EXT = 2'b11
   } rate_mode_t;

   typedef enum logic [1:0] {
      ST_CONVERT = 2'b00,
      ST_SLEEP = 2'b01
   } conv_state_t;

   typedef struct packed {
      logic done_n;
      logic fixed_low_bit;
      logic sign_flag;
      logic range_exceeded_flag;
      logic [19:0] code;
   } result_word_t;
endpackage

// >>> logic/result_encoder.sv
// Purpose: turns a signed input sample into the 24-bit result word
// Assumes: sample scale puts reference at 24'h100000
// Notes: purely combinational
`timescale 1ns/1ps
`default_nettype none
`include "adc_rate_defines.svh"
module result_encoder (
   input wire logic [23:0] vin_code,
   output adc_rate_pkg::result_word_t word
);
   logic signed [23:0] clamped;

   always_comb begin
      clamped = vin_code;
      if ($signed(vin_code) > $signed(`CLAMP_HI)) begin
         clamped = `CLAMP_HI;
      end else if ($signed(vin_code) < $signed(`CLAMP_LO)) begin
         clamped = `CLAMP_LO;
      end
      word.done_n = 1'b0;
      word.fixed_low_bit = 1'b0;
      // zero reads with the sign flag high
      word.sign_flag = (clamped >= 0);
      word.range_exceeded_flag = (clamped < 0) ||
         (clamped >= $signed(`FULL_SCALE));
      // modulo wrap: reference gives zero, -1 gives all ones
      word.code = clamped[19:0];
   end
endmodule
`default_nettype wire

// >>> logic/adc_rate_ctrl.sv
// Purpose: conversion clock select, result framing and serial output
// Assumes: pins are asynchronous to pclk; vin_code is on pclk
// Notes: registers on APB, one level interrupt
//
// The placing of the registers and register access over APB were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "adc_rate_defines.svh"
module adc_rate_ctrl #(
   parameter int conv_ticks = `CONV_TICKS,
   parameter int ext_timeout = `EXT_TIMEOUT_NS / `CLK_PERIOD_NS
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic irq,
   input wire logic freq_select_pin,
   input wire logic cs_n,
   input wire logic sck,
   output logic sdo,
   output logic sdo_oe_n,
   input wire logic [23:0] vin_code
);
   localparam int DIV60 = `CLK_HZ / `OSC60_HZ;
   localparam int DIV50 = `CLK_HZ / `OSC50_HZ;

   generate
      if (conv_ticks < 2 || conv_ticks > 32767 || ext_timeout < 2 ||
          ext_timeout > 16777215) begin : g_bad
         $error("conv_ticks or ext_timeout out of range");
      end
   endgenerate

   // pin synchronisers: stage 1 only feeds stage 2
   logic [2:0] f_sync, cs_sync, sck_sync;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         f_sync <= 3'h0;
         cs_sync <= 3'h7;
         sck_sync <= 3'h0;
      end else begin
         f_sync <= {f_sync[1:0], freq_select_pin};
         cs_sync <= {cs_sync[1:0], cs_n};
         sck_sync <= {sck_sync[1:0], sck};
      end
   end
   logic f_s, cs_s, f_rise, sck_fall, cs_rise;
   assign f_s = f_sync[1];
   assign cs_s = cs_sync[1];
   assign f_rise = f_sync[1] & ~f_sync[2];
   assign sck_fall = ~sck_sync[1] & sck_sync[2];
   assign cs_rise = cs_sync[1] & ~cs_sync[2];

   // mode detection and conversion clock
   logic ext_seen_reg, ext_seen_next;
   logic [23:0] ext_tmr_reg, ext_tmr_next;
   logic [9:0] div_reg, div_next;
   adc_rate_pkg::rate_mode_t det_mode, conv_mode_reg, conv_mode_next;
   logic [9:0] div_last;
   logic tick;

   always_comb begin
      ext_seen_next = ext_seen_reg;
      ext_tmr_next = ext_tmr_reg;
      if (f_rise) begin
         ext_seen_next = 1'b1;
         ext_tmr_next = 24'h0;
      end else if (ext_tmr_reg == 24'(ext_timeout - 1)) begin
         ext_seen_next = 1'b0;
      end else begin
         ext_tmr_next = ext_tmr_reg + 24'h1;
      end
      if (ext_seen_reg) begin
         det_mode = adc_rate_pkg::MODE_EXT;
      end else if (f_s) begin
         det_mode = adc_rate_pkg::MODE_INT50;
      end else begin
         det_mode = adc_rate_pkg::MODE_INT60;
      end
      div_last = (conv_mode_reg == adc_rate_pkg::MODE_INT50) ?
         10'(DIV50 - 1) : 10'(DIV60 - 1);
      div_next = (div_reg >= div_last) ? 10'h0 : div_reg + 10'h1;
      if (conv_mode_reg == adc_rate_pkg::MODE_EXT) begin
         tick = f_rise;
      end else begin
         tick = (div_reg >= div_last);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ext_seen_reg <= 1'b0;
         ext_tmr_reg <= 24'h0;
         div_reg <= 10'h0;
      end else begin
         ext_seen_reg <= ext_seen_next;
         ext_tmr_reg <= ext_tmr_next;
         div_reg <= div_next;
      end
   end

   // conversion and serial output
   adc_rate_pkg::result_word_t enc_word;
   result_encoder u_enc (
      .vin_code(vin_code),
      .word(enc_word)
   );

   adc_rate_pkg::conv_state_t state_reg, state_next;
   logic [14:0] conv_cnt_reg, conv_cnt_next;
   logic [4:0] bit_cnt_reg, bit_cnt_next;
   logic [23:0] shift_reg, shift_next;
   logic [23:0] result_reg, result_next;
   logic sdo_next;
   logic ev_done, ev_sent, ev_abort, run;
   logic [31:0] ctrl_reg;

   assign run = ctrl_reg[`CTRL_RUN_BIT];

   always_comb begin
      state_next = state_reg;
      conv_cnt_next = conv_cnt_reg;
      bit_cnt_next = bit_cnt_reg;
      shift_next = shift_reg;
      result_next = result_reg;
      conv_mode_next = conv_mode_reg;
      ev_done = 1'b0;
      ev_sent = 1'b0;
      ev_abort = 1'b0;
      case (state_reg)
         adc_rate_pkg::ST_CONVERT: begin
            if (tick && run) begin
               if (conv_cnt_reg == 15'(conv_ticks - 1)) begin
                  // fresh sample each time, nothing kept from before
                  shift_next = enc_word;
                  result_next = enc_word;
                  bit_cnt_next = 5'h0;
                  state_next = adc_rate_pkg::ST_SLEEP;
                  ev_done = 1'b1;
               end else begin
                  conv_cnt_next = conv_cnt_reg + 15'h1;
               end
            end
         end
         adc_rate_pkg::ST_SLEEP: begin
            if (cs_rise && bit_cnt_reg != 5'h0) begin
               ev_abort = 1'b1;
               state_next = adc_rate_pkg::ST_CONVERT;
            end else if (!cs_s && sck_fall) begin
               shift_next = {shift_reg[22:0], 1'b1};
               bit_cnt_next = bit_cnt_reg + 5'h1;
               if (bit_cnt_reg == 5'(`WORD_BITS - 1)) begin
                  ev_sent = 1'b1;
                  state_next = adc_rate_pkg::ST_CONVERT;
               end
            end
         end
         default: begin
            state_next = adc_rate_pkg::ST_CONVERT;
         end
      endcase
      if (state_next == adc_rate_pkg::ST_CONVERT &&
          state_reg != adc_rate_pkg::ST_CONVERT) begin
         conv_cnt_next = 15'h0;
         conv_mode_next = det_mode;
      end
      // done bit reads high while converting and after the word
      sdo_next = (state_next == adc_rate_pkg::ST_SLEEP) ?
         shift_next[23] : 1'b1;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg <= adc_rate_pkg::ST_CONVERT;
         conv_cnt_reg <= 15'h0;
         bit_cnt_reg <= 5'h0;
         shift_reg <= 24'hFFFFFF;
         result_reg <= 24'h0;
         conv_mode_reg <= adc_rate_pkg::MODE_INT60;
         sdo <= 1'b1;
         sdo_oe_n <= 1'b1;
      end else begin
         state_reg <= state_next;
         conv_cnt_reg <= conv_cnt_next;
         bit_cnt_reg <= bit_cnt_next;
         shift_reg <= shift_next;
         result_reg <= result_next;
         conv_mode_reg <= conv_mode_next;
         sdo <= sdo_next;
         sdo_oe_n <= cs_s;
      end
   end

   // APB slave: zero wait states, read data caught in setup
   logic [2:0] int_stat_reg, int_stat_next, int_mask_reg, int_mask_next;
   logic [31:0] ctrl_next, rdata_next;
   logic wr, hit, err_next, err_reg;

   always_comb begin
      wr = psel && penable && pwrite;
      hit = (paddr == `OFF_CTRL) || (paddr == `OFF_STATUS) ||
         (paddr == `OFF_RESULT) || (paddr == `OFF_INT_STAT) ||
         (paddr == `OFF_INT_MASK);
      ctrl_next = ctrl_reg;
      int_mask_next = int_mask_reg;
      int_stat_next = int_stat_reg;
      if (wr && paddr == `OFF_CTRL) begin
         ctrl_next = {31'h0, pwdata[`CTRL_RUN_BIT]};
      end
      if (wr && paddr == `OFF_INT_MASK) begin
         int_mask_next = pwdata[2:0];
      end
      if (wr && paddr == `OFF_INT_STAT) begin
         int_stat_next = int_stat_reg & ~pwdata[2:0];
      end
      // a new event wins over a clear in the same cycle
      int_stat_next = int_stat_next | {ev_abort, ev_sent, ev_done};
      rdata_next = prdata;
      err_next = err_reg;
      if (psel && !penable) begin
         err_next = !hit;
         case (paddr)
            `OFF_CTRL: rdata_next = ctrl_reg;
            `OFF_STATUS: rdata_next = {28'h0,
               state_reg == adc_rate_pkg::ST_SLEEP,
               state_reg == adc_rate_pkg::ST_CONVERT, conv_mode_reg};
            `OFF_RESULT: rdata_next = {8'h0, result_reg};
            `OFF_INT_STAT: rdata_next = {29'h0, int_stat_reg};
            `OFF_INT_MASK: rdata_next = {29'h0, int_mask_reg};
            default: rdata_next = 32'h0;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_reg <= `CTRL_RESET;
         int_mask_reg <= `INT_MASK_RESET;
         int_stat_reg <= 3'h0;
         prdata <= 32'h0;
         err_reg <= 1'b0;
         irq <= 1'b0;
      end else begin
         ctrl_reg <= ctrl_next;
         int_mask_reg <= int_mask_next;
         int_stat_reg <= int_stat_next;
         prdata <= rdata_next;
         err_reg <= err_next;
         irq <= |(int_stat_next & int_mask_next);
      end
   end
   assign pready = 1'b1;
   assign pslverr = psel && penable && err_reg;

   // checks
   // the divider may still stand above the 60Hz end in the cycle a new
   // mode is taken over from the 50Hz one
   div_bound_a: assert property (@(posedge pclk) disable iff (!presetn)
      (conv_mode_reg == adc_rate_pkg::MODE_INT60 && $stable(conv_mode_reg))
      |-> div_reg <= 10'(DIV60 - 1))
      else $error("internal divider overran");
   mode_pick_a: assert property (@(posedge pclk) disable iff (!presetn)
      (!ext_seen_reg && f_s) |-> det_mode == adc_rate_pkg::MODE_INT50)
      else $error("high pin did not pick 50Hz mode");
   ext_tick_a: assert property (@(posedge pclk) disable iff (!presetn)
      (state_reg == adc_rate_pkg::ST_CONVERT && run && f_rise &&
       conv_mode_reg == adc_rate_pkg::MODE_EXT &&
       conv_cnt_reg < 15'(conv_ticks - 1))
      |=> conv_cnt_reg == $past(conv_cnt_reg) + 15'h1)
      else $error("external edge not counted");
   fresh_start_a: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(state_reg == adc_rate_pkg::ST_CONVERT) |-> conv_cnt_reg == 15'h0)
      else $error("conversion did not start from zero");
   word_head_a: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(state_reg == adc_rate_pkg::ST_SLEEP) |->
      shift_reg[23:22] == 2'b00 && sdo == 1'b0)
      else $error("done and fixed bits not low");
   zero_code_a: assert property (@(posedge pclk) disable iff (!presetn)
      vin_code == 24'h0 |-> enc_word.code == 20'h0 &&
      !enc_word.range_exceeded_flag)
      else $error("zero input wrong code");
   clamp_hi_a: assert property (@(posedge pclk) disable iff (!presetn)
      $signed(vin_code) > $signed(`CLAMP_HI) |->
      enc_word.code == 20'h1FFFF && enc_word.range_exceeded_flag)
      else $error("over range not clamped");
   tail_high_a: assert property (@(posedge pclk) disable iff (!presetn)
      (state_reg == adc_rate_pkg::ST_SLEEP && ev_sent) |=> sdo[*2])
      else $error("sdo not high after word");
   mode_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
      (state_reg == adc_rate_pkg::ST_CONVERT &&
       $past(state_reg) == adc_rate_pkg::ST_CONVERT) |->
      $stable(conv_mode_reg))
      else $error("mode changed inside a conversion");
endmodule
`default_nettype wire

// >>> verif/host_reader.sv
// Purpose: host side of the serial result port
// Assumes: bit moves on sck fall, host samples it on sck rise
// Notes: sck idles low and stands still between frames
`timescale 1ns/1ps
`default_nettype none
module host_reader (
   input wire logic pclk,
   input wire logic sdo,
   input wire logic sdo_oe_n,
   output logic cs_n,
   output logic sck
);
   logic alt = 1'b0;
   logic line;
   int cyc = 0;
   int t_last = 0;
   always @(posedge pclk) begin
      alt <= ~alt;
      cyc <= cyc + 1;
   end
   // a released line with no pull shows the inverse of the driven value
   assign line = sdo_oe_n ? ~sdo : sdo;
   initial begin
      cs_n = 1'b1;
      sck = 1'b0;
   end
   // n clocks after done; dur counts from the last word end to done
   task automatic frame(input int n, input bit drop,
                        output logic [31:0] w, output int dur);
      int k;
      w = 32'h0;
      @(posedge pclk);
      cs_n <= 1'b0;
      repeat (4) @(posedge pclk);
      for (k = 0; k < 10000 && line !== 1'b0; k++) @(posedge pclk);
      dur = cyc - t_last;
      for (k = 0; k < n; k++) begin
         repeat (8) @(posedge pclk);
         sck <= 1'b1;
         w = {w[30:0], line};
         repeat (8) @(posedge pclk);
         sck <= 1'b0;
         if (k == 23) t_last = cyc;
      end
      repeat (8) @(posedge pclk);
      if (drop) cs_n <= 1'b1;
   endtask
endmodule
`default_nettype wire

// >>> verif/testbench.sv
// Purpose: self-checking bench for the converter control block
// Assumes: a conversion shortened to 8 ticks
// Notes: host_reader plays the serial host
`timescale 1ns/1ps
`default_nettype none
`include "adc_rate_defines.svh"
module testbench;
   localparam int ct = 8;
   typedef struct packed {
      logic [1:0] m;
      logic [23:0] vin;
      logic [23:0] w;
   } row_t;
   // m: 0 static low, 1 static high, 2 pin toggling
   row_t rows [9] = '{
      '{2'h2, 24'h000000, 24'h200000},
      '{2'h2, 24'h080000, 24'h280000},
      '{2'h2, 24'h0FFFFF, 24'h2FFFFF},
      '{2'h2, 24'h100000, 24'h300000},
      '{2'h2, 24'h11FFFF, 24'h31FFFF},
      '{2'h0, 24'h7FFFFF, 24'h31FFFF},
      '{2'h1, 24'hFFFFFF, 24'h1FFFFF},
      '{2'h2, 24'hFE0000, 24'h1E0000},
      '{2'h2, 24'h800000, 24'h1E0000}
   };
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [23:0] vin_code = 24'h0;
   logic ext_on = 1'b0;
   logic lvl = 1'b0;
   logic tog = 1'b0;
   logic [31:0] prdata;
   logic pready, pslverr, irq, sdo, sdo_oe_n, cs_n, sck, fsel;
   int fail_count = 0;
   int n_compared = 0;
   int cycles = 0;
   assign fsel = ext_on ? tog : lvl;

   adc_rate_ctrl #(.conv_ticks(ct), .ext_timeout(64)) i_dut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .irq(irq),
      .freq_select_pin(fsel), .cs_n(cs_n), .sck(sck), .sdo(sdo),
      .sdo_oe_n(sdo_oe_n), .vin_code(vin_code));
   host_reader i_host (.pclk(pclk), .sdo(sdo), .sdo_oe_n(sdo_oe_n),
      .cs_n(cs_n), .sck(sck));

   always #4 pclk = ~pclk;

   task automatic report_and_stop();
      if (fail_count == 0 && n_compared > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask

   // external conversion clock of 20 cycles; run time ceiling
   always @(posedge pclk) begin
      cycles <= cycles + 1;
      if (cycles % 10 == 9) tog <= ~tog;
      if (cycles == 90000) begin
         fail_count = fail_count + 1;
         report_and_stop();
      end
   end

   task automatic check(input string what, input logic [31:0] seen,
                        input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         fail_count++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic apb(input logic wr, input logic [11:0] a,
                      input logic [31:0] d, output logic [31:0] r,
                      output logic e);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   initial begin
      logic [31:0] r;
      logic [31:0] w;
      logic e;
      int dur;
      int p;
      int q;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      foreach (rows[i]) begin
         // let the running conversion end in its own mode first, so a
         // stopped external clock never strands it
         for (q = 0; q < 10000 && sdo !== 1'b0; q++) @(posedge pclk);
         @(posedge pclk);
         vin_code <= rows[i].vin;
         ext_on <= rows[i].m == 2'h2;
         lvl <= rows[i].m == 2'h1;
         p = rows[i].m == 2'h2 ? 20 : rows[i].m == 2'h1 ?
             `CLK_HZ / `OSC50_HZ : `CLK_HZ / `OSC60_HZ;
         repeat (100) @(posedge pclk);
         // first frame starts a conversion in the new mode
         i_host.frame(24, 1'b0, w, dur);
         i_host.frame(32, 1'b0, w, dur);
         check("word", w, {rows[i].w, 8'hFF});
         check("rate", 32'(dur >= (ct-1)*p && dur <= ct*p+30), 32'h1);
         apb(1'b0, `OFF_STATUS, 32'h0, r, e);
         check("mode", {30'h0, r[1:0]}, {30'h0, rows[i].m[1], rows[i].m != 2'h0});
         apb(1'b0, `OFF_RESULT, 32'h0, r, e);
         check("result", r, {8'h0, rows[i].w});
      end
      i_host.frame(5, 1'b1, w, dur);
      repeat (300) @(posedge pclk);
      check("oe_n", {31'h0, sdo_oe_n}, 32'h1);
      apb(1'b0, `OFF_INT_STAT, 32'h0, r, e);
      check("int_stat", r, 32'h7);
      check("irq", {31'h0, irq}, 32'h0);
      apb(1'b1, `OFF_INT_MASK, 32'h4, r, e);
      repeat (2) @(posedge pclk);
      check("irq", {31'h0, irq}, 32'h1);
      apb(1'b1, `OFF_INT_STAT, 32'h4, r, e);
      repeat (2) @(posedge pclk);
      check("irq", {31'h0, irq}, 32'h0);
      apb(1'b0, `OFF_INT_STAT, 32'h0, r, e);
      check("int_stat", r, 32'h3);
      apb(1'b0, 12'h020, 32'h0, r, e);
      check("unmapped", r, 32'h0);
      check("slverr", {31'h0, e}, 32'h1);
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (3) @(posedge pclk);
      check("reset", {29'h0, irq, sdo, sdo_oe_n}, 32'h3);
      presetn <= 1'b1;
      apb(1'b0, `OFF_CTRL, 32'h0, r, e);
      check("ctrl", r, `CTRL_RESET);
      apb(1'b0, `OFF_INT_MASK, 32'h0, r, e);
      check("mask", r, 32'h0);
      report_and_stop();
   end
endmodule
`default_nettype wire
